// ===== hw/stc_pkg.sv
package stc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and times
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1000000;
  localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int DELAY_MAX_S = 100;
  localparam logic [16:0] DELAY_MAX_MS = 17'(DELAY_MAX_S * MS_PER_S);
  localparam logic [16:0] DELAY_RST = 17'h00000;
  localparam int TRIG_PULSE_NS = 1000;
  localparam logic [7:0] PULSE_CYC = 8'((TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_NPOINTS = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_CLR = 8'h18;
  localparam logic [7:0] OFS_INT_EN = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_POS_BIT = 3;
  localparam int CTRL_POINT_BIT = 4;
  localparam int CTRL_FUNC_LSB = 5;
  localparam int CTRL_OPOL_BIT = 8;
  localparam int CTRL_OEN_BIT = 9;
  localparam int CTRL_CONT_BIT = 10;

  localparam int CMD_IMM_BIT = 0;
  localparam int CMD_SINGLE_BIT = 1;
  localparam int CMD_INIT_BIT = 2;
  localparam int CMD_ABORT_BIT = 3;

  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PEND_BIT = 2;
  localparam int STAT_POINT_LSB = 16;

  localparam int INT_ERR_BIT = 0;
  localparam int INT_END_BIT = 1;
  localparam int INT_ACC_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_BUS = 2'h2;

  localparam logic EDGE_NEG = 1'b0;
  localparam logic POS_WAIT_BEFORE_SAMPLING = 1'b0;
  localparam logic POS_WAIT_BEFORE_FREQ_SETUP = 1'b1;
  localparam logic POL_NEG = 1'b0;

  localparam logic [2:0] FUNC_BEFORE_SETUP_PULSE = 3'h0;
  localparam logic [2:0] FUNC_BEFORE_SAMPLING_PULSE = 3'h1;
  localparam logic [2:0] FUNC_AFTER_SAMPLING_PULSE = 3'h2;
  localparam logic [2:0] FUNC_READY_FOR_TRIGGER_LEVEL = 3'h3;
  localparam logic [2:0] FUNC_END_OF_SWEEP_PULSE = 3'h4;
  localparam logic [2:0] FUNC_MEASURING_LEVEL = 3'h5;

  localparam logic [1:0] TSTAT_HOLD = 2'h0;
  localparam logic [1:0] TSTAT_MEASURING_LEVEL = 2'h1;
  localparam logic [1:0] TSTAT_WAIT = 2'h2;
  localparam logic [1:0] TSTAT_NOT_READY = 2'h3;

  localparam logic [15:0] NPOINTS_RST = 16'h0065;

  typedef enum logic [5:0] {
    ST_HOLD = 6'b000001,
    ST_TRIGWAIT = 6'b000010,
    ST_DELAY = 6'b000100,
    ST_SETUP = 6'b001000,
    ST_SAMPLE = 6'b010000,
    ST_NOT_READY_STATE = 6'b100000
  } stc_state_t;

endpackage : stc_pkg

// ===== hw/stc_edge_sync.sv
`timescale 1ns/1ps
module stc_edge_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sigIn,
  input wire logic risingSel,
  output logic edgePulse
);
  import stc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } stc_sync_t;

  stc_sync_t r_r;
  stc_sync_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = sigIn;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    r_nxt.pulse = risingSel ? (r_r.s2 & ~r_r.s3) : (~r_r.s2 & r_r.s3);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign edgePulse = r_r.pulse;

endmodule : stc_edge_sync

// ===== hw/stc_delay_timer.sv
`timescale 1ns/1ps
module stc_delay_timer #(
  parameter int CYCLES_PER_MS = stc_pkg::CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic cancel,
  input wire logic [16:0] delayMs,
  output logic done
);
  import stc_pkg::*;

  typedef struct packed {
    logic busy;
    logic [17:0] preCnt;
    logic [16:0] msLeft;
    logic done;
  } stc_tmr_t;

  stc_tmr_t r_r;
  stc_tmr_t r_nxt;

  // Millisecond prescaler keeps the counter narrow over a 100 s span
  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    if (cancel) begin
      r_nxt.busy = 1'b0;
    end else if (start) begin
      r_nxt.busy = 1'b1;
      r_nxt.preCnt = '0;
      r_nxt.msLeft = delayMs;
    end else if (r_r.busy) begin
      if (r_r.preCnt == 18'(CYCLES_PER_MS - 1)) begin
        r_nxt.preCnt = '0;
        r_nxt.msLeft = 17'(r_r.msLeft - 17'h00001);
        if (r_r.msLeft <= 17'h00001) begin
          r_nxt.busy = 1'b0;
          r_nxt.done = 1'b1;
        end
      end else begin
        r_nxt.preCnt = 18'(r_r.preCnt + 18'h00001);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign done = r_r.done;

endmodule : stc_delay_timer

// ===== hw/stc_sweep_trigger.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module stc_sweep_trigger #(
  parameter int CYCLES_PER_MS = stc_pkg::CYC_PER_MS,
  parameter bit HAS_READY_LEVEL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extTrigIn,
  input wire logic measReady,
  input wire logic freqSettled,
  input wire logic sampleDone,
  output logic trigOut,
  output logic freqSetReq,
  output logic sampleReq,
  output logic [15:0] pointIndex,
  output logic irq
);
  import stc_pkg::*;

  localparam logic [2:0] FUNC_RST = HAS_READY_LEVEL ? FUNC_READY_FOR_TRIGGER_LEVEL : FUNC_END_OF_SWEEP_PULSE;

  typedef struct packed {
    stc_state_t st;
    logic [1:0] src;
    logic extEdge;
    logic waitPos;
    logic pointTrig;
    logic [2:0] outFunc;
    logic outPol;
    logic outEn;
    logic contInit;
    logic [16:0] delayMs;
    logic [15:0] nPoints;
    logic [15:0] point;
    logic postWait;
    logic singlePend;
    logic [2:0] intStat;
    logic [2:0] intEn;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic trigOut;
    logic freqSetReq;
    logic sampleReq;
    logic [7:0] pulseCnt;
  } stc_regs_t;

  stc_regs_t r_r;
  stc_regs_t r_nxt;
  logic extEdgeDet;
  logic delayDone;
  logic delayStart;
  logic delayCancel;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  stc_edge_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .sigIn(extTrigIn),
    .risingSel(r_r.extEdge),
    .edgePulse(extEdgeDet)
  );

  stc_delay_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_delay (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(delayStart),
    .cancel(delayCancel),
    .delayMs(r_r.delayMs),
    .done(delayDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic setupAcc;
  logic wrEn;
  logic mapped;
  logic [31:0] rdv;
  logic cmdImm;
  logic cmdSingle;
  logic cmdInit;
  logic cmdAbort;
  logic extSrc;
  logic inWait;
  logic goTrig;
  logic evErr;
  logic evEnd;
  logic evAcc;
  logic evSetup;
  logic evSample;
  logic evAfter;
  logic doProceed;
  logic doBegin;
  logic beginFirst;
  logic needWait;
  logic selPulse;
  logic actLvl;
  logic [15:0] nxtPoint;
  logic [1:0] stateCode;

  always_comb begin
    r_nxt = r_r;
    r_nxt.freqSetReq = 1'b0;
    r_nxt.sampleReq = 1'b0;
    evErr = 1'b0;
    evEnd = 1'b0;
    evAcc = 1'b0;
    evSetup = 1'b0;
    evSample = 1'b0;
    evAfter = 1'b0;
    doProceed = 1'b0;
    doBegin = 1'b0;
    beginFirst = 1'b0;
    needWait = 1'b0;
    selPulse = 1'b0;
    actLvl = 1'b0;
    delayStart = 1'b0;
    delayCancel = 1'b0;
    nxtPoint = 16'(r_r.point + 16'h0001);
    extSrc = (r_r.src == SRC_EXT);
    inWait = (r_r.st == ST_TRIGWAIT);

    // Trigger state code
    unique case (r_r.st)
      ST_HOLD: stateCode = TSTAT_HOLD;
      ST_NOT_READY_STATE: stateCode = TSTAT_NOT_READY;
      ST_TRIGWAIT: stateCode = TSTAT_WAIT;
      default: stateCode = TSTAT_MEASURING_LEVEL;
    endcase

    // APB: access phase is two cycles, pready from a flop
    setupAcc = psel & penable & ~r_r.pready;
    wrEn = psel & penable & pwrite & r_r.pready & ~r_r.pslverr;
    mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_INT_EN);
    rdv = '0;
    unique case (paddr)
      OFS_CTRL: begin
        rdv[CTRL_SRC_LSB +: 2] = r_r.src;
        rdv[CTRL_EDGE_BIT] = r_r.extEdge;
        rdv[CTRL_POS_BIT] = r_r.waitPos;
        rdv[CTRL_POINT_BIT] = r_r.pointTrig;
        rdv[CTRL_FUNC_LSB +: 3] = r_r.outFunc;
        rdv[CTRL_OPOL_BIT] = r_r.outPol;
        rdv[CTRL_OEN_BIT] = r_r.outEn;
        rdv[CTRL_CONT_BIT] = r_r.contInit;
      end
      OFS_DELAY: rdv[16:0] = r_r.delayMs;
      OFS_NPOINTS: rdv[15:0] = r_r.nPoints;
      OFS_STATUS: begin
        rdv[STAT_STATE_LSB +: 2] = stateCode;
        rdv[STAT_PEND_BIT] = r_r.singlePend;
        rdv[STAT_POINT_LSB +: 16] = r_r.point;
      end
      OFS_INT_STAT: rdv[2:0] = r_r.intStat;
      OFS_INT_EN: rdv[2:0] = r_r.intEn;
      default: rdv = '0;
    endcase
    r_nxt.pready = setupAcc;
    r_nxt.pslverr = setupAcc & ~mapped;
    if (setupAcc && !pwrite) begin
      r_nxt.prdata = mapped ? rdv : '0;
    end

    cmdImm = wrEn && (paddr == OFS_CMD) && pwdata[CMD_IMM_BIT];
    cmdSingle = wrEn && (paddr == OFS_CMD) && pwdata[CMD_SINGLE_BIT];
    cmdInit = wrEn && (paddr == OFS_CMD) && pwdata[CMD_INIT_BIT];
    cmdAbort = wrEn && (paddr == OFS_CMD) && pwdata[CMD_ABORT_BIT];

    if (wrEn && paddr == OFS_CTRL) begin
      if (pwdata[CTRL_SRC_LSB +: 2] != 2'h3) begin
        r_nxt.src = pwdata[CTRL_SRC_LSB +: 2];
      end
      r_nxt.extEdge = pwdata[CTRL_EDGE_BIT];
      r_nxt.waitPos = pwdata[CTRL_POS_BIT];
      r_nxt.pointTrig = pwdata[CTRL_POINT_BIT];
      // Unknown codes, and the ready level on the reduced variant, keep the old function
      if (pwdata[CTRL_FUNC_LSB +: 3] <= FUNC_MEASURING_LEVEL &&
          (HAS_READY_LEVEL || pwdata[CTRL_FUNC_LSB +: 3] != FUNC_READY_FOR_TRIGGER_LEVEL)) begin
        r_nxt.outFunc = pwdata[CTRL_FUNC_LSB +: 3];
      end
      r_nxt.outPol = pwdata[CTRL_OPOL_BIT];
      r_nxt.outEn = pwdata[CTRL_OEN_BIT];
      r_nxt.contInit = pwdata[CTRL_CONT_BIT];
    end
    if (wrEn && paddr == OFS_DELAY) begin
      if (pwdata[31]) begin
        r_nxt.delayMs = 17'h00000;
      end else if (pwdata > {15'h0000, DELAY_MAX_MS}) begin
        r_nxt.delayMs = DELAY_MAX_MS;
      end else begin
        r_nxt.delayMs = pwdata[16:0];
      end
    end
    if (wrEn && paddr == OFS_NPOINTS) begin
      r_nxt.nPoints = pwdata[15:0];
    end
    if (wrEn && paddr == OFS_INT_EN) begin
      r_nxt.intEn = pwdata[2:0];
    end

    // Software trigger checks, then the external edge and internal source triggers
    goTrig = 1'b0;
    if (cmdImm || cmdSingle) begin
      if (r_r.src != SRC_BUS) begin
        evErr = 1'b1;
      end else if (!inWait) begin
        evErr = 1'b1;
      end else begin
        goTrig = 1'b1;
        if (cmdSingle) begin
          r_nxt.singlePend = 1'b1;
        end
      end
    end
    if (inWait && extSrc && extEdgeDet) begin
      goTrig = 1'b1;
    end
    if (inWait && r_r.src == SRC_INT) begin
      goTrig = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sweep sequencer
    unique case (r_r.st)
      ST_HOLD: begin
        if (cmdInit || r_r.contInit) begin
          doBegin = 1'b1;
          beginFirst = 1'b1;
        end
      end
      ST_TRIGWAIT: begin
        if (goTrig) begin
          evAcc = 1'b1;
          if (extSrc && r_r.delayMs != 17'h00000) begin
            r_nxt.st = ST_DELAY;
            delayStart = 1'b1;
          end else begin
            doProceed = 1'b1;
          end
        end
      end
      ST_DELAY: begin
        if (delayDone) begin
          doProceed = 1'b1;
        end
      end
      ST_SETUP: begin
        if (freqSettled) begin
          // postWait stays set so the trigger goes straight to sampling
          if (r_r.postWait) begin
            r_nxt.st = ST_TRIGWAIT;
          end else begin
            r_nxt.st = ST_SAMPLE;
            r_nxt.sampleReq = 1'b1;
            evSample = 1'b1;
          end
        end
      end
      ST_SAMPLE: begin
        if (sampleDone) begin
          evAfter = 1'b1;
          r_nxt.point = nxtPoint;
          if (nxtPoint >= r_r.nPoints) begin
            evEnd = 1'b1;
            r_nxt.singlePend = 1'b0;
            r_nxt.st = ST_HOLD;
            if (r_r.contInit) begin
              doBegin = 1'b1;
              beginFirst = 1'b1;
            end
          end else begin
            doBegin = 1'b1;
          end
        end
      end
      ST_NOT_READY_STATE: begin
        if (measReady) begin
          r_nxt.st = ST_HOLD;
        end
      end
    endcase

    // Trigger consumed: after the wait before sampling go sample, else set up
    if (doProceed) begin
      if (r_r.postWait || (extSrc && r_r.waitPos == POS_WAIT_BEFORE_SAMPLING && r_r.point != 16'h0000 &&
          !r_r.pointTrig)) begin
        r_nxt.st = ST_SAMPLE;
        r_nxt.postWait = 1'b0;
        r_nxt.sampleReq = 1'b1;
        evSample = 1'b1;
      end else begin
        r_nxt.st = ST_SETUP;
        r_nxt.freqSetReq = 1'b1;
        evSetup = 1'b1;
      end
    end

    // New point: trigger wait on the first point, or every point with point trigger and the external source
    if (doBegin) begin
      if (beginFirst) begin
        r_nxt.point = 16'h0000;
      end
      needWait = beginFirst || (extSrc && r_r.pointTrig);
      if (needWait && extSrc && r_r.waitPos == POS_WAIT_BEFORE_SAMPLING) begin
        r_nxt.st = ST_SETUP;
        r_nxt.postWait = 1'b1;
        r_nxt.freqSetReq = 1'b1;
        evSetup = 1'b1;
      end else if (needWait) begin
        r_nxt.st = ST_TRIGWAIT;
        r_nxt.postWait = 1'b0;
      end else begin
        r_nxt.st = ST_SETUP;
        r_nxt.postWait = 1'b0;
        r_nxt.freqSetReq = 1'b1;
        evSetup = 1'b1;
      end
    end

    // Abort and loss of readiness override the sequence
    if (cmdAbort || !measReady) begin
      r_nxt.st = measReady ? ST_HOLD : ST_NOT_READY_STATE;
      r_nxt.postWait = 1'b0;
      r_nxt.singlePend = 1'b0;
      r_nxt.freqSetReq = 1'b0;
      r_nxt.sampleReq = 1'b0;
      delayCancel = 1'b1;
      delayStart = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger output waveform
    unique case (r_r.outFunc)
      FUNC_BEFORE_SETUP_PULSE: selPulse = evSetup;
      FUNC_BEFORE_SAMPLING_PULSE: selPulse = evSample;
      FUNC_AFTER_SAMPLING_PULSE: selPulse = evAfter;
      FUNC_END_OF_SWEEP_PULSE: selPulse = evEnd;
      default: selPulse = 1'b0;
    endcase
    if (selPulse) begin
      r_nxt.pulseCnt = PULSE_CYC;
    end else if (r_r.pulseCnt != 8'h00) begin
      r_nxt.pulseCnt = 8'(r_r.pulseCnt - 8'h01);
    end
    unique case (r_r.outFunc)
      FUNC_READY_FOR_TRIGGER_LEVEL: actLvl = (r_nxt.st == ST_TRIGWAIT);
      FUNC_MEASURING_LEVEL: actLvl = (r_nxt.st != ST_HOLD) && (r_nxt.st != ST_NOT_READY_STATE);
      default: actLvl = (r_nxt.pulseCnt != 8'h00);
    endcase
    // Disabled output rests at the inactive level of the chosen polarity
    r_nxt.trigOut = (r_r.outEn & actLvl) ^ (r_r.outPol == POL_NEG);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over clear
    if (wrEn && paddr == OFS_INT_CLR) begin
      r_nxt.intStat = r_r.intStat & ~pwdata[2:0];
    end
    r_nxt.intStat[INT_ERR_BIT] = r_nxt.intStat[INT_ERR_BIT] | evErr;
    r_nxt.intStat[INT_END_BIT] = r_nxt.intStat[INT_END_BIT] | evEnd;
    r_nxt.intStat[INT_ACC_BIT] = r_nxt.intStat[INT_ACC_BIT] | evAcc;
    r_nxt.irq = |(r_nxt.intStat & r_nxt.intEn);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
      r_r.st <= ST_HOLD;
      r_r.src <= SRC_INT;
      r_r.extEdge <= EDGE_NEG;
      r_r.waitPos <= POS_WAIT_BEFORE_SAMPLING;
      r_r.outFunc <= FUNC_RST;
      r_r.outPol <= POL_NEG;
      r_r.outEn <= 1'b0;
      r_r.delayMs <= DELAY_RST;
      r_r.nPoints <= NPOINTS_RST;
      r_r.trigOut <= 1'b1;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign trigOut = r_r.trigOut;
  assign freqSetReq = r_r.freqSetReq;
  assign sampleReq = r_r.sampleReq;
  assign pointIndex = r_r.point;
  assign irq = r_r.irq;

endmodule : stc_sweep_trigger

// ===== dv/stc_measuring_level_model.sv
`timescale 1ns/1ps
module stc_measuring_level_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic freqSetReq,
  input wire logic sampleReq,
  input wire logic [7:0] lat,
  output logic freqSettled,
  output logic sampleDone
);
  // Down counters, strobe at one: lat 0 answers on the second edge after the request, larger lat is slow
  int fCnt;
  int sCnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fCnt <= 0;
      sCnt <= 0;
      freqSettled <= 1'b0;
      sampleDone <= 1'b0;
    end else begin
      freqSettled <= fCnt == 1;
      sampleDone <= sCnt == 1;
      fCnt <= freqSetReq ? int'(lat) + 1 : (fCnt > 0 ? fCnt - 1 : 0);
      sCnt <= sampleReq ? int'(lat) + 1 : (sCnt > 0 ? sCnt - 1 : 0);
    end
  end
endmodule : stc_measuring_level_model

// ===== dv/stc_sweep_trigger_assertions.sv
`timescale 1ns/1ps
module stc_sweep_trigger_chk
  import stc_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic measReady,
  input wire logic trigOut,
  input wire logic freqSetReq,
  input wire logic sampleReq,
  input wire logic [15:0] pointIndex
);
  // Output enable and polarity, shadowed at the write edge
  logic [1:0] outCfg_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      outCfg_r <= 2'h0;
    end else if (psel && penable && pwrite && pready && !pslverr && paddr == OFS_CTRL) begin
      outCfg_r <= pwdata[CTRL_OEN_BIT:CTRL_OPOL_BIT];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ACCESS_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  AST_ERR_UNALIGNED: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access without error");
  AST_CMD_READ_ZERO: assert property (pready && !pwrite && paddr == OFS_CMD |-> prdata == 32'h00000000)
    else $error("command read not zero");
  AST_OUT_OFF: assert property (outCfg_r == $past(outCfg_r, 2) && !outCfg_r[1] |-> trigOut == !outCfg_r[0])
    else $error("disabled output not inactive");
  AST_NOT_READY_QUIET: assert property (!measReady [*3] |-> !freqSetReq && !sampleReq)
    else $error("request while not ready");
  AST_POINT_STEP: assert property ($changed(pointIndex) && pointIndex != 16'h0000 |-> pointIndex == $past(pointIndex) + 16'h0001)
    else $error("point index skipped");
  AST_REQ_APART: assert property (freqSetReq |-> !sampleReq ##1 !freqSetReq)
    else $error("setup and sample requests overlap");
endmodule : stc_sweep_trigger_chk
bind stc_sweep_trigger stc_sweep_trigger_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_chk (.*);

// ===== dv/stc_sweep_trigger_tb.sv
`timescale 1ns/1ps
module stc_sweep_trigger_tb;
  import stc_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, lat = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic extTrigIn = 1'b0, measReady = 1'b1, err;
  logic pready, pslverr, freqSettled, sampleDone, trigOut, freqSetReq, sampleReq, irq;
  logic [15:0] pointIndex;
  int failures = 0, n_tests = 0, nFreq = 0, nSamp = 0, f0, s0;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Small ms count keeps delay runs short
  stc_sweep_trigger #(.CYCLES_PER_MS(4)) i_dut (.*);
  stc_measuring_level_model i_model (.*);
  always @(posedge ref_clk) begin
    nFreq <= nFreq + int'(freqSetReq);
    nSamp <= nSamp + int'(sampleReq);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask : rd
  task automatic waitst(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS);
      n++;
    end while (q[1:0] !== s && n < 200);
    chk(32'(q[1:0]), 32'(s));
  endtask : waitst
  // Level held long enough for sync and a 1 ms delay
  task automatic ext(input logic v);
    extTrigIn <= v;
    repeat (30) @(posedge ref_clk);
  endtask : ext
  ////////////////////////////////////////
  task automatic t_reset;
    rd(OFS_CTRL);
    chk(q, 32'h00000060);
    rd(OFS_DELAY);
    chk(q, 32'h00000000);
    rd(OFS_STATUS);
    chk(q, 32'h00000000);
    rd(8'h20);
    chk(32'(err), 32'h1);
    rd(8'h02);
    chk(32'(err), 32'h1);
    rd(OFS_CMD);
    chk(q, 32'h00000000);
    chk(32'(err), 32'h0);
    chk(32'(trigOut), 32'h1);
  endtask : t_reset
  task automatic t_clamp;
    wr(OFS_DELAY, 32'hFFFFFFFF);
    rd(OFS_DELAY);
    chk(q, 32'h00000000);
    wr(OFS_DELAY, 32'h00030D40);
    rd(OFS_DELAY);
    chk(q, 32'h000186A0);
    wr(OFS_DELAY, 32'h00000001);
  endtask : t_clamp
  task automatic t_sw_error;
    wr(OFS_INT_EN, 32'h00000001);
    wr(OFS_CMD, 32'h00000001);
    rd(OFS_INT_STAT);
    chk(q, 32'h00000001);
    chk(32'(irq), 32'h1);
    wr(OFS_INT_CLR, 32'h00000007);
    @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    wr(OFS_CTRL, 32'(SRC_BUS));
    wr(OFS_CMD, 32'h00000002);
    rd(OFS_INT_STAT);
    chk(q, 32'h00000001);
    wr(OFS_INT_CLR, 32'h00000007);
    wr(OFS_INT_EN, 32'h00000000);
  endtask : t_sw_error
  task automatic t_bus;
    lat <= 8'h14;
    wr(OFS_NPOINTS, 32'h00000002);
    wr(OFS_CTRL, 32'h00000362);
    wr(OFS_CMD, 32'h00000004);
    waitst(TSTAT_WAIT);
    chk(32'(trigOut), 32'h1);
    wr(OFS_CMD, 32'h00000002);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h5);
    chk(32'(trigOut), 32'h0);
    waitst(TSTAT_HOLD);
    chk(32'(q[2:0]), 32'h0);
    rd(OFS_INT_STAT);
    chk(q, 32'h00000006);
    wr(OFS_CMD, 32'h00000004);
    waitst(TSTAT_WAIT);
    wr(OFS_CMD, 32'h00000001);
    rd(OFS_STATUS);
    chk(32'(q[2:0]), 32'h1);
    waitst(TSTAT_HOLD);
    wr(OFS_INT_CLR, 32'h00000007);
  endtask : t_bus
  task automatic t_ext_point;
    lat <= 8'h00;
    wr(OFS_CTRL, 32'h00000015);
    ext(1'b1);
    ext(1'b0);
    rd(OFS_INT_STAT);
    chk(q, 32'h00000000);
    s0 = nSamp;
    f0 = nFreq;
    wr(OFS_CMD, 32'h00000004);
    waitst(TSTAT_WAIT);
    chk(32'(nSamp - s0), 32'h0);
    ext(1'b1);
    waitst(TSTAT_WAIT);
    chk(32'(pointIndex), 32'h1);
    chk(32'(nSamp - s0), 32'h1);
    ext(1'b0);
    rd(OFS_STATUS);
    chk(32'(q[1:0]), 32'(TSTAT_WAIT));
    ext(1'b1);
    waitst(TSTAT_HOLD);
    chk(32'(nSamp - s0), 32'h2);
    chk(32'(nFreq - f0), 32'h2);
  endtask : t_ext_point
  task automatic t_ext_setup;
    wr(OFS_CTRL, 32'h0000038D);
    ext(1'b0);
    f0 = nFreq;
    wr(OFS_CMD, 32'h00000004);
    waitst(TSTAT_WAIT);
    chk(32'(nFreq - f0), 32'h0);
    ext(1'b1);
    waitst(TSTAT_HOLD);
    chk(32'(nFreq - f0), 32'h2);
    chk(32'(trigOut), 32'h1);
    repeat (PULSE_CYC) @(posedge ref_clk);
    chk(32'(trigOut), 32'h0);
  endtask : t_ext_setup
  task automatic t_not_ready;
    measReady <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(OFS_STATUS);
    chk(32'(q[1:0]), 32'(TSTAT_NOT_READY));
    measReady <= 1'b1;
    waitst(TSTAT_HOLD);
  endtask : t_not_ready
  ////////////////////////////////////////
  task automatic final_report;
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    #300000;
    failures++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_clamp();
    t_sw_error();
    t_bus();
    t_ext_point();
    t_ext_setup();
    t_not_ready();
    final_report();
  end
endmodule : stc_sweep_trigger_tb
